// ==== common/aab_pkg.sv ====
`default_nettype none

package aab_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [11:0] AAB_OFS_ACC    = 12'h000;
  localparam logic [11:0] AAB_OFS_STATUS = 12'h004;
  localparam logic [11:0] AAB_OFS_BANK   = 12'h008;
  localparam logic [11:0] AAB_OFS_INSTR  = 12'h00C;
  localparam logic [11:0] AAB_FILE_BASE  = 12'h200;
  localparam logic [2:0]  AAB_FILE_WIN   = AAB_FILE_BASE[11:9];

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int          AAB_FADDR_W    = 7;
  localparam int          AAB_FILE_LOCS  = 128;
  localparam int          AAB_BANK_W_DEF = 2;
  localparam logic [7:0]  AAB_ACC_RST    = 8'h00;
  localparam logic [31:0] AAB_INSTR_RST  = 32'h0000_0000;
  localparam logic [7:0]  AAB_FILE_RST   = 8'h00;

  // ------------------------------------------------------------
  // Operations, instruction word and flags
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    AAB_ADD_LITERAL_OP,
    AAB_ADD_FILE_OP,
    AAB_AND_FILE_OP,
    AAB_AND_LITERAL_OP,
    AAB_BIT_CLEAR_OP,
    AAB_BIT_SET_OP
  } aab_op_t;

  typedef struct packed {
    logic [7:0]             rsvd;
    logic [7:0]             literal;
    logic                   pad_a;
    logic [AAB_FADDR_W-1:0] file_addr;
    logic                   pad_b;
    logic [2:0]             bit_idx;
    logic                   dest;
    aab_op_t                op;
  } aab_instr_t;

  typedef struct packed {
    logic z;
    logic digit_carry_flag;
    logic c;
  } aab_flags_t;

  localparam aab_flags_t AAB_FLAGS_RST = 3'h0;

endpackage : aab_pkg

`default_nettype wire

// ==== design/aab_alu.sv ====
// Function
// - Add literal into accumulator, set all flags
// - Add accumulator and file, set all flags
// - Add-file result to accumulator or file
// - AND accumulator with file, Z only
// - AND-file result to accumulator or file
// - AND literal into accumulator, Z only
// - Clear one file bit, flags untouched
// - Set one file bit, flags untouched
// - Seven-bit file address within selected bank
`timescale 1ns/1ps
`default_nettype none

module aab_alu #(
  parameter int BANK_W = aab_pkg::AAB_BANK_W_DEF
) (
  input  wire logic               clk_i,      // 200 MHz core clock
  input  wire logic               rst_i,      // Sync reset, active high
  input  wire logic               wb_cyc_i,   // Bus cycle
  input  wire logic               wb_stb_i,   // Bus strobe
  input  wire logic               wb_we_i,    // Write enable
  input  wire logic [11:0]        wb_adr_i,   // Byte address
  input  wire logic [31:0]        wb_dat_i,   // Write data
  input  wire logic [3:0]         wb_sel_i,   // Byte lanes
  output logic      [31:0]        wb_dat_o,   // Read data
  output logic                    wb_ack_o,   // Acknowledge
  output logic      [7:0]         acc_o,      // Accumulator
  output aab_pkg::aab_flags_t     flags_o     // Status flags
);
  import aab_pkg::*;

  localparam int IDX_W = BANK_W + AAB_FADDR_W;
  localparam int DEPTH = (1 << BANK_W) * AAB_FILE_LOCS;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic              ack_q;
  logic [7:0]        acc_q;
  aab_flags_t        flags_q;
  logic [BANK_W-1:0] bank_q;
  logic [31:0]       instr_q;
  logic [7:0]        file_q [DEPTH];

  logic             req_w, wr_w, hit_acc_w, hit_stat_w, hit_bank_w, hit_instr_w, hit_file_w;
  logic             exec_w;
  aab_instr_t       instr_w;
  logic [IDX_W-1:0] idx_w, bus_idx_w;

  assign req_w       = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_w        = req_w & wb_we_i;
  assign hit_acc_w   = wb_adr_i == AAB_OFS_ACC;
  assign hit_stat_w  = wb_adr_i == AAB_OFS_STATUS;
  assign hit_bank_w  = wb_adr_i == AAB_OFS_BANK;
  assign hit_instr_w = wb_adr_i == AAB_OFS_INSTR;
  assign hit_file_w  = (wb_adr_i[11:9] == AAB_FILE_WIN) && (wb_adr_i[1:0] == 2'h0);
  assign instr_w     = aab_instr_t'(wb_dat_i);
  // Instruction writes missing any of byte lanes 0-2 would execute garbage, so they are dropped
  assign exec_w      = wr_w & hit_instr_w & (&wb_sel_i[2:0]);
  assign idx_w       = {bank_q, instr_w.file_addr};
  assign bus_idx_w   = {bank_q, wb_adr_i[8:2]};

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  logic [7:0] file_rd_w, operand_w, and_w, mask_w;
  logic [8:0] add_w;
  logic [4:0] nib_w;
  logic       add_c_w, add_half_w;
  logic       is_lit_w;

  assign is_lit_w  = (instr_w.op == AAB_ADD_LITERAL_OP) || (instr_w.op == AAB_AND_LITERAL_OP);
  assign file_rd_w = file_q[idx_w];
  assign operand_w = is_lit_w ? instr_w.literal : file_rd_w;
  assign add_w     = {1'b0, acc_q} + {1'b0, operand_w};
  assign nib_w     = {1'b0, acc_q[3:0]} + {1'b0, operand_w[3:0]};
  assign add_c_w   = add_w[8];
  assign add_half_w = nib_w[4];
  assign and_w     = acc_q & operand_w;
  assign mask_w    = 8'h01 << instr_w.bit_idx;

  // Zero test shared by the add and AND result paths
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // ------------------------------------------------------------
  // Accumulator
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= AAB_ACC_RST;
    end else if (exec_w) begin
      unique case (instr_w.op)
        AAB_ADD_LITERAL_OP: acc_q <= add_w[7:0];
        AAB_ADD_FILE_OP:    if (!instr_w.dest) acc_q <= add_w[7:0];
        AAB_AND_FILE_OP:    if (!instr_w.dest) acc_q <= and_w;
        AAB_AND_LITERAL_OP: acc_q <= and_w;
        AAB_BIT_CLEAR_OP:   acc_q <= acc_q;
        AAB_BIT_SET_OP:     acc_q <= acc_q;
        default:            acc_q <= acc_q;
      endcase
    end else if (wr_w && hit_acc_w && wb_sel_i[0]) begin
      acc_q <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= AAB_FLAGS_RST;
    end else if (exec_w) begin
      unique case (instr_w.op)
        AAB_ADD_LITERAL_OP, AAB_ADD_FILE_OP: begin
          flags_q <= '{z: is_zero(add_w[7:0]), digit_carry_flag: add_half_w, c: add_c_w};
        end
        AAB_AND_FILE_OP, AAB_AND_LITERAL_OP: begin
          flags_q.z <= is_zero(and_w);
        end
        AAB_BIT_CLEAR_OP:   flags_q <= flags_q;
        AAB_BIT_SET_OP:     flags_q <= flags_q;
        default:            flags_q <= flags_q;
      endcase
    end else if (wr_w && hit_stat_w && wb_sel_i[0]) begin
      flags_q <= aab_flags_t'(wb_dat_i[2:0]);
    end
  end

  // ------------------------------------------------------------
  // File registers, bank select, last instruction
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_q[i] <= AAB_FILE_RST;
      end
    end else if (exec_w) begin
      unique case (instr_w.op)
        AAB_ADD_FILE_OP:    if (instr_w.dest) file_q[idx_w] <= add_w[7:0];
        AAB_AND_FILE_OP:    if (instr_w.dest) file_q[idx_w] <= and_w;
        AAB_BIT_CLEAR_OP:   file_q[idx_w] <= file_rd_w & ~mask_w;
        AAB_BIT_SET_OP:     file_q[idx_w] <= file_rd_w | mask_w;
        AAB_ADD_LITERAL_OP, AAB_AND_LITERAL_OP: ;
        default: ;
      endcase
    end else if (wr_w && hit_file_w && wb_sel_i[0]) begin
      file_q[bus_idx_w] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= '0;
    end else if (wr_w && hit_bank_w && wb_sel_i[0]) begin
      bank_q <= wb_dat_i[BANK_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= AAB_INSTR_RST;
    end else if (exec_w) begin
      instr_q <= wb_dat_i;
    end
  end

  // ------------------------------------------------------------
  // Bus answer: one wait state, ack always given, unmapped reads zero
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= req_w;
      if (req_w && !wb_we_i) begin
        if (hit_acc_w)        wb_dat_o <= {24'h00_0000, acc_q};
        else if (hit_stat_w)  wb_dat_o <= {29'h0000_0000, flags_q};
        else if (hit_bank_w)  wb_dat_o <= 32'(bank_q);
        else if (hit_instr_w) wb_dat_o <= instr_q;
        else if (hit_file_w)  wb_dat_o <= {24'h00_0000, file_q[bus_idx_w]};
        else                  wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign acc_o    = acc_q;
  assign flags_o  = flags_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_exec(aab_op_t o);
    exec_w && instr_w.op == o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_pulse: assert property (req_w |=> s_ack_pulse)
    else $error("ack not a one-cycle pulse");

  a_add_lit_acc: assert property (s_exec(AAB_ADD_LITERAL_OP) |=>
      acc_q == 8'($past(acc_q) + $past(operand_w)) && flags_q.c == $past(add_c_w))
    else $error("add literal result wrong");

  a_add_file_flags: assert property (s_exec(AAB_ADD_FILE_OP) |=>
      flags_q.digit_carry_flag == $past(add_half_w) && flags_q.z == ($past(add_w) == 9'h100
      || $past(add_w) == 9'h000))
    else $error("add file flags wrong");

  a_add_file_dest: assert property (s_exec(AAB_ADD_FILE_OP) |=>
      ($past(instr_w.dest) ? acc_q == $past(acc_q) && file_q[$past(idx_w)] == $past(add_w[7:0])
                           : acc_q == $past(add_w[7:0])))
    else $error("add file destination wrong");

  a_and_file_zero: assert property (s_exec(AAB_AND_FILE_OP) |=>
      flags_q.c == $past(flags_q.c) && flags_q.digit_carry_flag == $past(flags_q.digit_carry_flag)
      && flags_q.z == ($past(and_w) == 8'h00))
    else $error("and file flags wrong");

  a_and_file_dest: assert property (s_exec(AAB_AND_FILE_OP) ##0 instr_w.dest |=>
      acc_q == $past(acc_q) && file_q[$past(idx_w)] == $past(and_w))
    else $error("and file to file wrong");

  a_and_lit_acc: assert property (s_exec(AAB_AND_LITERAL_OP) |=>
      acc_q == ($past(acc_q) & $past(instr_w.literal)) && $stable(flags_q.c))
    else $error("and literal result wrong");

  a_bit_clear: assert property (s_exec(AAB_BIT_CLEAR_OP) |=>
      file_q[$past(idx_w)][$past(instr_w.bit_idx)] == 1'b0 && $stable(flags_q))
    else $error("bit clear wrong");

  a_bit_set: assert property (s_exec(AAB_BIT_SET_OP) |=>
      file_q[$past(idx_w)][$past(instr_w.bit_idx)] == 1'b1 && $stable(flags_q)
      && $stable(acc_q))
    else $error("bit set wrong");

endmodule : aab_alu

`default_nettype wire

// ==== verification/aab_alu_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, a, b); end end

module aab_alu_tb;
  import aab_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [11:0] adr;
  logic [31:0] dat, rdat, r;
  logic [3:0]  sel;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  acc_o, e;
  aab_flags_t  flags_o;
  int          fail_count, total_checks;

  aab_alu u_aab_alu (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_o(acc_o), .flags_o(flags_o));

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    // The wait ends on wb_ack_o; only the watchdog ends a wait that never gets an answer
    do begin @(posedge clk_i); end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 4'hF, rdat);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0, 4'hF, rdat);
  endtask : rd

  function automatic logic [11:0] fa(input logic [6:0] f);
    return AAB_FILE_BASE | {3'h0, f, 2'b00};
  endfunction : fa

  // Instruction word built field by field, sel narrows to refuse
  task automatic ex(input aab_op_t op, input logic d, input logic [2:0] b,
                    input logic [6:0] f, input logic [7:0] k, input logic [3:0] s);
    xfer(1'b1, AAB_OFS_INSTR, {8'h0, k, 1'b0, f, 1'b0, b, d, op}, s, rdat);
  endtask : ex

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(AAB_OFS_ACC);    `CHK(rdat, 32'h0)
    rd(AAB_OFS_STATUS); `CHK(rdat, 32'h0)
    rd(fa(7'h7F));      `CHK(rdat, 32'h0)
    rd(12'h100);        `CHK(rdat, 32'h0)
  endtask : t_reset

  task automatic t_add_lit();
    wr(AAB_OFS_ACC, 8'hFF);
    ex(AAB_ADD_LITERAL_OP, 1'b0, 3'h0, 7'h0, 8'h01, 4'hF);
    `CHK(acc_o, 8'h00)
    `CHK(flags_o, aab_flags_t'(3'b111))
    wr(AAB_OFS_ACC, 8'h12);
    ex(AAB_ADD_LITERAL_OP, 1'b0, 3'h0, 7'h0, 8'h34, 4'hF);
    `CHK(acc_o, 8'h46)
    `CHK(flags_o, aab_flags_t'(3'b000))
  endtask : t_add_lit

  task automatic t_add_file();
    wr(fa(7'h7F), 8'h08);
    wr(AAB_OFS_ACC, 8'h08);
    ex(AAB_ADD_FILE_OP, 1'b0, 3'h0, 7'h7F, 8'h00, 4'hF);
    `CHK(acc_o, 8'h10)
    `CHK(flags_o, aab_flags_t'(3'b010))
    rd(fa(7'h7F)); `CHK(rdat, 32'h08)
    ex(AAB_ADD_FILE_OP, 1'b1, 3'h0, 7'h7F, 8'h00, 4'hF);
    rd(fa(7'h7F)); `CHK(rdat, 32'h18)
    `CHK(acc_o, 8'h10)
  endtask : t_add_file

  task automatic t_and();
    wr(AAB_OFS_STATUS, 8'h03);
    wr(AAB_OFS_ACC, 8'hF0);
    wr(fa(7'h00), 8'h0F);
    ex(AAB_AND_FILE_OP, 1'b1, 3'h0, 7'h00, 8'h00, 4'hF);
    rd(fa(7'h00)); `CHK(rdat, 32'h00)
    `CHK(acc_o, 8'hF0)
    `CHK(flags_o, aab_flags_t'(3'b111))
    ex(AAB_AND_FILE_OP, 1'b0, 3'h0, 7'h7F, 8'h00, 4'hF);
    `CHK(acc_o, 8'h10)
    `CHK(flags_o, aab_flags_t'(3'b011))
    ex(AAB_AND_LITERAL_OP, 1'b0, 3'h0, 7'h0, 8'h0F, 4'h1);
    `CHK(acc_o, 8'h10)
    ex(AAB_AND_LITERAL_OP, 1'b0, 3'h0, 7'h0, 8'h0F, 4'hF);
    `CHK(acc_o, 8'h00)
    `CHK(flags_o, aab_flags_t'(3'b111))
    rd(AAB_OFS_INSTR); `CHK(rdat, 32'h000F_0003)
  endtask : t_and

  task automatic t_bits();
    wr(AAB_OFS_STATUS, 8'h05);
    wr(AAB_OFS_BANK, 8'h01);
    rd(AAB_OFS_BANK); `CHK(rdat, 32'h1)
    for (int i = 0; i < 8; i++) begin
      ex(AAB_BIT_SET_OP, 1'b0, 3'(i), 7'h05, 8'h00, 4'hF);
      e = 8'((2 << i) - 1);
      rd(fa(7'h05)); `CHK(rdat, {24'h0, e})
      `CHK(flags_o, aab_flags_t'(3'b101))
    end
    wr(AAB_OFS_BANK, 8'h00);
    rd(fa(7'h05)); `CHK(rdat, 32'h0)
    wr(AAB_OFS_BANK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      ex(AAB_BIT_CLEAR_OP, 1'b0, 3'(i), 7'h05, 8'h00, 4'hF);
      e = 8'(9'h1FF << (i + 1));
      rd(fa(7'h05)); `CHK(rdat, {24'h0, e})
      `CHK(flags_o, aab_flags_t'(3'b101))
    end
    `CHK(acc_o, 8'h00)
  endtask : t_bits

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Whole run is under two hundred cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end

  initial begin
    fail_count = 0; total_checks = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 12'h000; dat = 32'h0; sel = 4'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_add_lit();
    t_add_file();
    t_and();
    t_bits();
    finish_test();
  end
endmodule : aab_alu_tb

`default_nettype wire
